// ==== inc/tpx_pkg.sv ====
// constants and types for the twisted-pair transceiver control block
// assumes a 100 MHz bit-clock domain with one synchronous reset
package tpx_pkg;
  // clock and bit cell timing
  localparam int CLK_NS = 10;
  localparam int CELL_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;
  localparam logic [4:0] CELL_CYC = 5'(CELL_NS / CLK_NS);
  localparam logic [4:0] HALF_CYC = 5'(CELL_NS / CLK_NS / 2);
  localparam logic [4:0] MID_PH = 5'(CELL_NS * 3 / 4 / CLK_NS);
  localparam logic [4:0] SOI_PH = 5'(CELL_NS * 3 / 2 / CLK_NS);
  localparam int EOP_CELLS = 2;
  localparam logic [4:0] EOP_CYC = 5'(EOP_CELLS * CELL_NS / CLK_NS);
  localparam int SQE_CELLS = 10;
  localparam logic [6:0] SQE_CYC = 7'(SQE_CELLS * CELL_NS / CLK_NS);
  localparam int SQ_IDLE_CELLS = 8;
  localparam logic [6:0] SQ_IDLE_CYC = 7'(SQ_IDLE_CELLS * CELL_NS / CLK_NS);
  // millisecond intervals, each chosen inside its allowed window
  localparam logic [9:0] JAB_MS = 10'h032;       // 50 ms
  localparam logic [9:0] JAB_REC_MS = 10'h1F4;   // 500 ms
  localparam logic [9:0] LINK_FAIL_MS = 10'h064; // 100 ms
  localparam logic [9:0] PULSE_GAP_MS = 10'h004; // 4 ms
  localparam logic [9:0] POL_RST_MS = 10'h070;   // 112 ms
  localparam logic [9:0] LTX_MS = 10'h010;       // 16 ms
  // polarity and link counts
  localparam logic [3:0] OPP_PULSES = 4'h8;
  localparam logic [2:0] REV_FRAMES = 3'h4;
  // timer slots
  localparam int T_JAB = 0;
  localparam int T_LNK = 1;
  localparam int T_GAP = 2;
  localparam int T_POL = 3;
  localparam int T_LTX = 4;
  localparam int N_TMR = 5;
  // register indices
  localparam logic [2:0] A_TX_STAT = 3'h0;
  localparam logic [2:0] A_TX_MODE = 3'h1;
  localparam logic [2:0] A_XCV_MODE = 3'h2;
  localparam logic [2:0] A_RX_CTRL = 3'h3;
  localparam logic [2:0] A_XCV_STAT = 3'h4;
  // field positions
  localparam int TXS_CRS = 6;
  localparam int TXS_JAB = 3;
  localparam int TXM_FLOOP = 1;
  localparam int XM_LTE_N = 5;
  localparam int RXC_SUPP = 0;
  localparam int XS_POL = 3;
  localparam int XS_SQE = 1;
  localparam int XS_LFAIL = 0;
  // transmit sequencer states
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_DATA = 4'h2,
    TX_EOP = 4'h4,
    TX_LINK = 4'h8
  } tpx_tx_st_t;
endpackage

// ==== design/tpx_ctrl.sv ====
// twisted-pair transceiver control: encoder, decoder, jabber, sqe,
// polarity, collision, loopback, link integrity and a register port
// assumes a single 100 MHz clock and digital squelch/pulse qualifiers
// Notes on behaviour
// - one is low then high, 100 ns cell
// - invalid end symbol after enable drops
// - idle line sends link pulses when enabled
// - overlong transmit: jabber, flag, event
// - jabber ends after long idle period
// - sqe on collision path after good send
// - receiver idles after eight quiet bit times
// - carrier sense and recovered clock with data
// - eight opposite pulses or four bad frames
// - polarity flip clears both counters
// - polarity defaults after long link fail
// - no link test: frames decide polarity
// - auto correction, reversed state reported
// - collision on simultaneous pair activity
// - line data overrides auto loopback data, forced loop ignores the line
// - encoded data looped to decoder
// - no auto loop in fail or jabber
// - forced loop keeps line quiet
// - own looped frames may skip storage
// - link fail after silence, stops transmit
// - closely spaced link pulses are ignored
// - packet or two pulses restore link
`timescale 1ns/1ps
`default_nettype none

module tpx_ctrl #(
  parameter int unsigned P_MS_CYC = tpx_pkg::MS_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_tx_en,
  input wire logic i_tx_data,
  output logic o_tx_bit_req,
  output logic o_rx_data,
  output logic o_rx_clk,
  output logic o_crs,
  output logic o_collision_indicate_path,
  output logic o_rx_store_en,
  output logic o_jabber_evt,
  output logic o_link_fail,
  input wire logic i_pair_receive_input,
  input wire logic i_pair_rx_sq,
  input wire logic i_link_pulse_p,
  input wire logic i_link_pulse_n,
  output logic o_pair_tx_pos,
  output logic o_pair_tx_neg
);

  // software controls and sticky status
  logic forced_loop_ctrl_ff; // transmit mode forced loop bit
  logic lte_n_ff;            // link test enable, low active
  logic suppress_own_loop_rx_ff;
  logic jstat_ff;            // sticky jabber status
  logic sqe_ok_ff;
  logic [7:0] rdata_ff;
  logic [7:0] rd_val;
  wire link_test_en = ~lte_n_ff;

  // shared millisecond prescaler and timers
  logic [31:0] pre_ff;
  logic [9:0] tmr_ff [tpx_pkg::N_TMR];
  logic [tpx_pkg::N_TMR-1:0] tmr_clr;
  wire ms_tick = (pre_ff == 32'(P_MS_CYC - 1));

  // transmit sequencer
  tpx_pkg::tpx_tx_st_t st_ff, nxt_st;
  logic [4:0] cnt_ff, nxt_cnt;
  logic bit_ff, nxt_bit;
  logic pos_ff, neg_ff;
  logic jab_ff, jev_ff, col_seen_ff;
  logic [6:0] sqe_cnt_ff;
  logic col_ff;

  // decoder and link state
  logic din_ff, dprev_ff, loop_ff;
  logic [4:0] ph_ff;
  logic [6:0] q_ff;
  logic crs_ff, rxd_ff, rxclk_ff, soi_ff, frm_loop_ff, store_ff;
  logic lfail_ff;
  logic [1:0] pass_ff;
  logic pol_inv_ff;
  logic [3:0] opp_ff;
  logic [2:0] rev_ff;

  // named timer views
  wire [9:0] jab_ms = tmr_ff[tpx_pkg::T_JAB];
  wire [9:0] lnk_ms = tmr_ff[tpx_pkg::T_LNK];
  wire [9:0] gap_ms = tmr_ff[tpx_pkg::T_GAP];
  wire [9:0] pol_ms = tmr_ff[tpx_pkg::T_POL];
  wire [9:0] ltx_ms = tmr_ff[tpx_pkg::T_LTX];

  // transmit decode
  wire in_data = (st_ff == tpx_pkg::TX_DATA);
  wire in_eop = (st_ff == tpx_pkg::TX_EOP);
  wire in_link = (st_ff == tpx_pkg::TX_LINK);
  wire tx_busy = in_data | in_eop;
  wire cell_end = (cnt_ff == tpx_pkg::CELL_CYC - 5'h01);
  wire eop_end = (cnt_ff == tpx_pkg::EOP_CYC - 5'h01);
  wire line_ok = ~forced_loop_ctrl_ff & ~jab_ff & ~lfail_ff;
  wire lp_due = link_test_en & (ltx_ms >= tpx_pkg::LTX_MS);
  // first half carries the inverse, second half the bit itself
  wire enc_lvl = in_data ? ((cnt_ff < tpx_pkg::HALF_CYC) ? ~bit_ff
                 : bit_ff) : (in_eop | in_link);
  // link pulses go out even in link fail, but never under forced loop
  wire tx_line_on = (tx_busy & line_ok)
                    | (in_link & ~forced_loop_ctrl_ff);

  // jabber watchdog
  wire jab_set = ~jab_ff & i_tx_en & (jab_ms >= tpx_pkg::JAB_MS);
  wire jab_clr = jab_ff & ~i_tx_en
                 & (jab_ms >= tpx_pkg::JAB_REC_MS);

  // collision and sqe
  wire col = i_pair_rx_sq & tx_busy & tx_line_on;
  wire sqe_go = in_eop & eop_end & ~col_seen_ff & line_ok;
  wire sqe_act = (sqe_cnt_ff != 7'h00);

  // loopback selection: line activity wins over auto-looped data; forced loop always loops
  wire use_loop = forced_loop_ctrl_ff
                  | (tx_busy & ~i_pair_rx_sq & line_ok);
  wire line_c = i_pair_receive_input ^ pol_inv_ff;
  wire sig = loop_ff ? tx_busy : i_pair_rx_sq;
  wire edge_seen = din_ff ^ dprev_ff;
  wire mid = edge_seen & ((ph_ff >= tpx_pkg::MID_PH) | ~crs_ff);
  wire crs_rise = ~crs_ff & mid & sig;
  wire crs_fall = crs_ff & (q_ff == tpx_pkg::SQ_IDLE_CYC - 7'h01);
  wire pkt_in = crs_rise & ~loop_ff;
  wire rev_frame = crs_fall & ~frm_loop_ff & ~soi_ff;

  // link pulse qualification
  wire pulse_any = i_link_pulse_p | i_link_pulse_n;
  wire pulse_ok = pulse_any & link_test_en
                  & (gap_ms >= tpx_pkg::PULSE_GAP_MS);
  wire act = (crs_ff & ~frm_loop_ff) | pulse_ok;
  wire lfail_set = link_test_en & ~lfail_ff
                   & (lnk_ms >= tpx_pkg::LINK_FAIL_MS);
  wire lfail_clr = ~link_test_en | pkt_in
                   | (pass_ff == 2'h1 & pulse_ok);

  // polarity decisions
  wire exp_p = pulse_ok & (pol_inv_ff ? i_link_pulse_n : i_link_pulse_p);
  wire opp_p = pulse_ok & (pol_inv_ff ? i_link_pulse_p : i_link_pulse_n);
  wire flip = (opp_p & (opp_ff == tpx_pkg::OPP_PULSES - 4'h1))
              | (rev_frame & (rev_ff == tpx_pkg::REV_FRAMES - 3'h1));
  wire pol_rst = lfail_ff & (pol_ms >= tpx_pkg::POL_RST_MS);

  // timer clears: jabber counts busy time, then idle time
  assign tmr_clr[tpx_pkg::T_JAB] = jab_ff ? i_tx_en : ~i_tx_en;
  assign tmr_clr[tpx_pkg::T_LNK] = act | ~link_test_en;
  assign tmr_clr[tpx_pkg::T_GAP] = pulse_any;
  assign tmr_clr[tpx_pkg::T_POL] = ~lfail_ff | act;
  assign tmr_clr[tpx_pkg::T_LTX] = in_link;

  // prescaler shared by every slow timer
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || ms_tick) pre_ff <= 32'h0000_0000;
    else pre_ff <= pre_ff + 32'h0000_0001;
  end

  // saturating millisecond timers, one per slot
  for (genvar g = 0; g < tpx_pkg::N_TMR; g++) begin : g_tmr
    always_ff @(posedge i_clk) begin
      if (!i_rst_n || tmr_clr[g]) tmr_ff[g] <= 10'h000;
      else if (ms_tick && tmr_ff[g] != 10'h3FF)
        tmr_ff[g] <= tmr_ff[g] + 10'h001;
    end
  end

  // transmit sequencer next state
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff + 5'h01;
    nxt_bit = bit_ff;
    case (st_ff)
      tpx_pkg::TX_IDLE: begin
        nxt_cnt = 5'h00;
        if (i_tx_en && !jab_ff) begin
          nxt_st = tpx_pkg::TX_DATA;
          nxt_bit = i_tx_data;
        end else if (lp_due) begin
          nxt_st = tpx_pkg::TX_LINK;
        end
      end
      tpx_pkg::TX_DATA: begin
        if (jab_ff) begin
          // the watchdog cuts the frame short
          nxt_st = tpx_pkg::TX_IDLE;
          nxt_cnt = 5'h00;
        end else if (cell_end) begin
          nxt_cnt = 5'h00;
          if (i_tx_en) nxt_bit = i_tx_data;
          else nxt_st = tpx_pkg::TX_EOP;
        end
      end
      tpx_pkg::TX_EOP: begin
        if (eop_end) begin
          nxt_st = tpx_pkg::TX_IDLE;
          nxt_cnt = 5'h00;
        end
      end
      tpx_pkg::TX_LINK: begin
        if (cell_end) begin
          nxt_st = tpx_pkg::TX_IDLE;
          nxt_cnt = 5'h00;
        end
      end
      default: begin
        nxt_st = tpx_pkg::TX_IDLE;
        nxt_cnt = 5'h00;
      end
    endcase
  end

  // bit taken now; the controller presents the next one
  assign o_tx_bit_req = in_data & cell_end & ~jab_ff & i_tx_en;

  // transmit registers and line drivers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_ff <= tpx_pkg::TX_IDLE;
      cnt_ff <= 5'h00;
      bit_ff <= 1'b0;
      pos_ff <= 1'b0;
      neg_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      bit_ff <= nxt_bit;
      pos_ff <= tx_line_on & enc_lvl;
      neg_ff <= tx_line_on & ~enc_lvl;
    end
  end

  // jabber state, event pulse and collision memory
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      jab_ff <= 1'b0;
      jev_ff <= 1'b0;
      col_seen_ff <= 1'b0;
    end else begin
      jab_ff <= jab_set | (jab_ff & ~jab_clr);
      jev_ff <= jab_set;
      if (st_ff == tpx_pkg::TX_IDLE) col_seen_ff <= 1'b0;
      else if (col) col_seen_ff <= 1'b1;
    end
  end

  // sqe burst on the collision path, status kept until next frame
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sqe_cnt_ff <= 7'h00;
      sqe_ok_ff <= 1'b0;
      col_ff <= 1'b0;
    end else begin
      if (sqe_go) sqe_cnt_ff <= tpx_pkg::SQE_CYC;
      else if (sqe_act) sqe_cnt_ff <= sqe_cnt_ff - 7'h01;
      if (sqe_go) sqe_ok_ff <= 1'b1;
      else if (nxt_st == tpx_pkg::TX_DATA && !in_data) sqe_ok_ff <= 1'b0;
      col_ff <= col | sqe_act;
    end
  end

  // decoder input stage and phase counter
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      din_ff <= 1'b0;
      dprev_ff <= 1'b0;
      loop_ff <= 1'b0;
      ph_ff <= 5'h1F;
    end else begin
      din_ff <= use_loop ? enc_lvl : line_c;
      dprev_ff <= din_ff;
      loop_ff <= use_loop;
      if (mid) ph_ff <= 5'h00;
      else if (ph_ff != 5'h1F) ph_ff <= ph_ff + 5'h01;
    end
  end

  // carrier sense, squelch idle and recovered data
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q_ff <= 7'h00;
      crs_ff <= 1'b0;
      rxd_ff <= 1'b0;
      rxclk_ff <= 1'b0;
      soi_ff <= 1'b1;
      frm_loop_ff <= 1'b0;
      store_ff <= 1'b1;
    end else begin
      // quiet time only counts while the signal is below squelch
      if (sig || !crs_ff) q_ff <= 7'h00;
      else q_ff <= q_ff + 7'h01;
      if (crs_rise) crs_ff <= 1'b1;
      else if (crs_fall) crs_ff <= 1'b0;
      // no recovered clock once the signal is gone: the quiet tail and a
      // wandering idle line must not deliver bits
      rxclk_ff <= mid & sig;
      if (mid) rxd_ff <= din_ff;
      // level one and a half cells after the last data edge
      if (ph_ff == tpx_pkg::SOI_PH) soi_ff <= din_ff;
      if (crs_rise) begin
        frm_loop_ff <= loop_ff;
        store_ff <= ~(loop_ff & suppress_own_loop_rx_ff);
      end
    end
  end

  // link monitor
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      lfail_ff <= 1'b0;
      pass_ff <= 2'h0;
    end else begin
      if (lfail_set) lfail_ff <= 1'b1;
      else if (lfail_clr) lfail_ff <= 1'b0;
      if (!lfail_ff) pass_ff <= 2'h0;
      else if (pulse_ok && pass_ff != 2'h3) pass_ff <= pass_ff + 2'h1;
    end
  end

  // polarity detector and correction
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pol_inv_ff <= 1'b0;
      opp_ff <= 4'h0;
      rev_ff <= 3'h0;
    end else begin
      if (pol_rst) pol_inv_ff <= 1'b0;
      else if (flip) pol_inv_ff <= ~pol_inv_ff;
      if (flip || pol_rst) begin
        opp_ff <= 4'h0;
        rev_ff <= 3'h0;
      end else begin
        if (exp_p) opp_ff <= 4'h0;
        else if (opp_p) opp_ff <= opp_ff + 4'h1;
        if (rev_frame) rev_ff <= rev_ff + 3'h1;
      end
    end
  end

  // register writes; a new jabber beats a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      forced_loop_ctrl_ff <= 1'b0;
      lte_n_ff <= 1'b0;
      suppress_own_loop_rx_ff <= 1'b0;
      jstat_ff <= 1'b0;
    end else begin
      if (i_wr && i_addr == tpx_pkg::A_TX_MODE)
        forced_loop_ctrl_ff <= i_wdata[tpx_pkg::TXM_FLOOP];
      if (i_wr && i_addr == tpx_pkg::A_XCV_MODE)
        lte_n_ff <= i_wdata[tpx_pkg::XM_LTE_N];
      if (i_wr && i_addr == tpx_pkg::A_RX_CTRL)
        suppress_own_loop_rx_ff <= i_wdata[tpx_pkg::RXC_SUPP];
      if (jab_set) jstat_ff <= 1'b1;
      else if (i_wr && i_addr == tpx_pkg::A_TX_STAT
               && i_wdata[tpx_pkg::TXS_JAB]) jstat_ff <= 1'b0;
    end
  end

  // read value; unmapped indices read zero
  always_comb begin
    rd_val = 8'h00;
    case (i_addr)
      tpx_pkg::A_TX_STAT: begin
        rd_val[tpx_pkg::TXS_CRS] = crs_ff;
        rd_val[tpx_pkg::TXS_JAB] = jstat_ff;
      end
      tpx_pkg::A_TX_MODE: rd_val[tpx_pkg::TXM_FLOOP] = forced_loop_ctrl_ff;
      tpx_pkg::A_XCV_MODE: rd_val[tpx_pkg::XM_LTE_N] = lte_n_ff;
      tpx_pkg::A_RX_CTRL:
        rd_val[tpx_pkg::RXC_SUPP] = suppress_own_loop_rx_ff;
      tpx_pkg::A_XCV_STAT: begin
        rd_val[tpx_pkg::XS_POL] = pol_inv_ff;
        rd_val[tpx_pkg::XS_SQE] = sqe_ok_ff;
        rd_val[tpx_pkg::XS_LFAIL] = lfail_ff;
      end
      default: rd_val = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) rdata_ff <= 8'h00;
    else rdata_ff <= i_rd ? rd_val : 8'h00;
  end

  assign o_rdata = rdata_ff;
  assign o_rx_data = rxd_ff;
  assign o_rx_clk = rxclk_ff;
  assign o_crs = crs_ff;
  assign o_collision_indicate_path = col_ff;
  assign o_rx_store_en = store_ff;
  assign o_jabber_evt = jev_ff;
  assign o_link_fail = lfail_ff;
  assign o_pair_tx_pos = pos_ff;
  assign o_pair_tx_neg = neg_ff;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_eop_hold;
    st_ff == tpx_pkg::TX_EOP [*8];
  endsequence
  sequence s_sqe;
    o_collision_indicate_path [*8];
  endsequence

  property p_enc_mid;
    (in_data && cnt_ff == tpx_pkg::HALF_CYC - 5'h01 && bit_ff
     && tx_line_on && !jab_set) |=> o_pair_tx_neg ##1 o_pair_tx_pos;
  endproperty
  a_enc_mid: assert property (p_enc_mid)
    else $error("one cell not low then high");

  property p_eop;
    (in_data && cell_end && !i_tx_en && !jab_ff) |=> s_eop_hold;
  endproperty
  a_eop: assert property (p_eop)
    else $error("end symbol missing");

  property p_link_tx;
    (in_link && !forced_loop_ctrl_ff) |=> o_pair_tx_pos;
  endproperty
  a_link_tx: assert property (p_link_tx)
    else $error("link pulse not driven");

  property p_jab;
    jab_set |=> jab_ff && jstat_ff ##1 !in_data;
  endproperty
  a_jab: assert property (p_jab)
    else $error("jabber did not stop transmit");

  property p_jab_exit;
    $fell(jab_ff) |-> $past(jab_ms) >= tpx_pkg::JAB_REC_MS;
  endproperty
  a_jab_exit: assert property (p_jab_exit)
    else $error("jabber left too early");

  property p_sqe;
    sqe_go |=> sqe_ok_ff ##1 s_sqe;
  endproperty
  a_sqe: assert property (p_sqe)
    else $error("sqe burst missing");

  property p_pol_flip;
    (flip && !pol_rst) |=> pol_inv_ff != $past(pol_inv_ff);
  endproperty
  a_pol_flip: assert property (p_pol_flip)
    else $error("polarity not corrected");

  property p_pol_clr;
    $changed(pol_inv_ff) |-> opp_ff == 4'h0 && rev_ff == 3'h0;
  endproperty
  a_pol_clr: assert property (p_pol_clr)
    else $error("polarity counters not cleared");

  property p_col;
    col |=> o_collision_indicate_path;
  endproperty
  a_col: assert property (p_col)
    else $error("collision not reported");

  property p_force_off;
    (forced_loop_ctrl_ff && $past(forced_loop_ctrl_ff))
      |-> !o_pair_tx_pos && !o_pair_tx_neg;
  endproperty
  a_force_off: assert property (p_force_off)
    else $error("line driven in forced loop");

  property p_lfail;
    (link_test_en && !lfail_ff && lnk_ms >= tpx_pkg::LINK_FAIL_MS)
      |=> lfail_ff ##1 !(tx_busy && tx_line_on);
  endproperty
  a_lfail: assert property (p_lfail)
    else $error("link fail not entered");

endmodule // tpx_ctrl

`default_nettype wire

// ==== bench/tpx_line_model.sv ====
// far-end model of the twisted-pair line: frames, link pulses, noise
// assumes the bench calls its tasks; one task active at a time
`timescale 1ns/1ps
`default_nettype none

module tpx_line_model (
  input wire logic i_clk,
  output logic o_rxd,
  output logic o_sq,
  output logic o_lp_p,
  output logic o_lp_n
);
  logic lvl = 1'b0; // line level while a frame is sent
  logic act = 1'b0; // frame in progress, signal above squelch
  logic noise_ff = 1'b0; // released line has no bias, so it wanders
  initial begin
    o_lp_p = 1'b0;
    o_lp_n = 1'b0;
  end
  // noise keeps changing so a stale level never looks like data
  always @(posedge i_clk) noise_ff <= ~noise_ff;
  assign o_rxd = act ? lvl : noise_ff;
  assign o_sq = act;
  // one manchester frame, then a high start-of-idle before release
  task send_frame(input logic [63:0] b, input int n);
    int i;
    @(posedge i_clk);
    for (i = 0; i < n; i++) begin
      act <= 1'b1;
      lvl <= ~b[i];
      repeat (5) @(posedge i_clk);
      lvl <= b[i];
      repeat (5) @(posedge i_clk);
    end
    lvl <= 1'b1;
    repeat (20) @(posedge i_clk);
    act <= 1'b0;
  endtask
  // one detected link pulse of the chosen polarity
  task pulse(input logic neg);
    @(posedge i_clk);
    if (neg) o_lp_n <= 1'b1;
    else o_lp_p <= 1'b1;
    @(posedge i_clk);
    o_lp_p <= 1'b0;
    o_lp_n <= 1'b0;
  endtask
endmodule // tpx_line_model
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the twisted-pair transceiver control block
// assumes a 20-cycle millisecond so link and jabber times stay short
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_tx_en = 1'b0;
  logic i_tx_data = 1'b0;
  logic [7:0] o_rdata;
  logic o_tx_bit_req, o_rx_data, o_rx_clk, o_crs, o_col, o_store;
  logic o_jab, o_link_fail, o_pos, o_neg, rxd, sq, lp_p, lp_n;
  logic [63:0] tb_bits, p_bits; // bits sent by bench and far end
  logic [7:0] d; // last read data
  logic rx_q[$]; // recovered bits
  int err_count = 0;
  int check_count = 0;
  int k;

  tpx_ctrl #(.P_MS_CYC(20)) tpx_ctrl_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_tx_en(i_tx_en), .i_tx_data(i_tx_data),
    .o_tx_bit_req(o_tx_bit_req), .o_rx_data(o_rx_data),
    .o_rx_clk(o_rx_clk), .o_crs(o_crs), .o_collision_indicate_path(o_col),
    .o_rx_store_en(o_store), .o_jabber_evt(o_jab),
    .o_link_fail(o_link_fail), .i_pair_receive_input(rxd),
    .i_pair_rx_sq(sq), .i_link_pulse_p(lp_p), .i_link_pulse_n(lp_n),
    .o_pair_tx_pos(o_pos), .o_pair_tx_neg(o_neg));
  tpx_line_model tpx_line_model_i (.i_clk(i_clk), .o_rxd(rxd), .o_sq(sq),
    .o_lp_p(lp_p), .o_lp_n(lp_n));

  always #5 i_clk = ~i_clk;
  // collect every recovered bit for later comparison
  always @(negedge i_clk) if (o_rx_clk === 1'b1) rx_q.push_back(o_rx_data);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // expected {pos, neg} for one half cell; both low when line is off
  function automatic logic [1:0] drv(input logic on, input logic lvl);
    drv = on ? {lvl, ~lvl} : 2'b00;
  endfunction
  task results;
    $display("mismatches %0d of %0d checks", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // a used-up wait bound counts as a mismatch and ends the run
  task tmo(input int n, input int lim);
    if (n >= lim) begin
      chk(n, 0);
      results();
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [2:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask
  // start only after an idle link pulse so the start is not delayed
  task wait_lp;
    for (k = 0; k < 400 && o_pos !== 1'b1; k++) @(negedge i_clk);
    tmo(k, 400);
    repeat (20) @(negedge i_clk);
  endtask
  // last 16 recovered bits against the tail of the source frame
  task chk_rx(input logic [63:0] src);
    int i;
    int sz;
    sz = rx_q.size();
    chk(sz >= 16, 1'b1);
    if (sz >= 16)
      for (i = 0; i < 16; i++) chk(rx_q[sz - 16 + i], src[16 + i]);
  endtask
  // f = {line on, sqe expected, carrier expected, collision expected}
  task tx_frame(input logic [3:0] f, input int n);
    int c;
    int j;
    rx_q.delete();
    @(posedge i_clk);
    i_tx_en <= 1'b1;
    i_tx_data <= tb_bits[0];
    for (c = 1; c <= 10 * n + 130; c++) begin
      @(posedge i_clk);
      j = (c - 1) / 10;
      if ((c - 1) % 10 == 0 && j + 1 < n) i_tx_data <= tb_bits[j + 1];
      if (c - 1 == 10 * (n - 1)) i_tx_en <= 1'b0;
      @(negedge i_clk);
      j = c / 10;
      if (c % 10 == 4 && j < n)
        chk({o_pos, o_neg}, drv(f[3], ~tb_bits[j]));
      if (c % 10 == 9 && j < n)
        chk({o_pos, o_neg}, drv(f[3], tb_bits[j]));
      if (c % 10 == 0 && j > 0 && j < n) chk(o_tx_bit_req, 1'b1);
      if (c == 10 * n + 10) chk({o_pos, o_neg}, {f[3], 1'b0});
      if (c == 50) chk(o_crs, f[1]);
      if (c == 100) chk(o_col, f[0]);
      if (c == 10 * n + 30) chk(o_col, f[2]);
      if (c == 10 * n + 130) chk(o_col, 1'b0);
    end
  endtask

  initial begin
    int a;
    k = $urandom(32'h80B8B8EA);
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // every register clears to zero, unmapped ones read zero
    for (a = 0; a < 8; a++) begin
      rd(3'(a));
      chk(d, 8'h00);
    end
    wr(3'h6, 8'($urandom));
    rd(3'h6);
    chk(d, 8'h00);
    chk(o_crs, 1'b0);
    chk(o_store, 1'b1);
    // plain frame: line drive, loop back and sqe afterwards
    tb_bits = {$urandom, $urandom};
    tb_bits[15:0] = 16'h5555;
    wait_lp();
    tx_frame(4'b1110, 32);
    chk_rx(tb_bits);
    chk(o_crs, 1'b0);
    rd(3'h4);
    chk(d[1], 1'b1);
    // far end talks at the same time: collision, line data wins
    tpx_line_model_i.pulse(1'b0);
    tb_bits = {$urandom, $urandom};
    p_bits = {$urandom, $urandom};
    p_bits[15:0] = 16'h5555;
    wait_lp();
    fork
      tx_frame(4'b1011, 32);
      tpx_line_model_i.send_frame(p_bits, 32);
    join
    chk_rx(p_bits);
    // forced loop keeps the line quiet; own frames not stored
    wr(3'h1, 8'h02);
    wr(3'h3, 8'h01);
    tb_bits = {$urandom, $urandom};
    tb_bits[15:0] = 16'h5555;
    fork
      tx_frame(4'b0010, 32);
      begin
        repeat (200) @(negedge i_clk);
        chk(o_store, 1'b0);
      end
    join
    chk_rx(tb_bits);
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h00);
    // silence brings link fail, which stops line and auto loop
    for (k = 0; k < 2500 && o_link_fail !== 1'b1; k++) @(negedge i_clk);
    tmo(k, 2500);
    rd(3'h4);
    chk(d[0], 1'b1);
    wait_lp();
    tx_frame(4'b0000, 32);
    chk(rx_q.size(), 0);
    // closely spaced pulses are dropped, a second spaced one restores
    repeat (4) begin
      tpx_line_model_i.pulse(1'b0);
      repeat (40) @(posedge i_clk);
    end
    chk(o_link_fail, 1'b1);
    repeat (60) @(posedge i_clk);
    tpx_line_model_i.pulse(1'b0);
    repeat (5) @(negedge i_clk);
    chk(o_link_fail, 1'b0);
    // eight opposite pulses flip the polarity, seven do not
    for (a = 0; a < 8; a++) begin
      repeat (100) @(posedge i_clk);
      tpx_line_model_i.pulse(1'b1);
      rd(3'h4);
      chk(d[3], a == 7);
    end
    // a long silence in link fail restores default polarity
    for (k = 0; k < 2500 && o_link_fail !== 1'b1; k++) @(negedge i_clk);
    tmo(k, 2500);
    repeat (2400) @(posedge i_clk);
    rd(3'h4);
    chk(d[3], 1'b0);
    // endless transmit trips the watchdog near 50 ms
    @(posedge i_clk);
    i_tx_en <= 1'b1;
    i_tx_data <= 1'($urandom);
    for (k = 0; k < 1200 && o_jab !== 1'b1; k++) @(negedge i_clk);
    tmo(k, 1200);
    chk(k >= 975 && k <= 1030, 1'b1);
    rd(3'h0);
    chk(d[3], 1'b1);
    wr(3'h0, 8'h08);
    rd(3'h0);
    chk(d[3], 1'b0);
    @(posedge i_clk);
    i_tx_en <= 1'b0;
    // after more than the recovery time of idle a frame may start again
    repeat (10500) @(posedge i_clk);
    i_tx_en <= 1'b1;
    for (k = 0; k < 30 && o_tx_bit_req !== 1'b1; k++) @(negedge i_clk);
    tmo(k, 30);
    @(posedge i_clk);
    i_tx_en <= 1'b0;
    results();
  end
endmodule // tb
`default_nettype wire
